/* core/cba_pkg.sv */
// How it works
// - master asserts request only while it truly needs the bus
// - master starts only with grant sampled asserted and bus idle
// - grant removed as frame asserts still leaves a valid transaction
// - transaction ends and bus idles when frame and ready both high
// - keep request for more transactions, else drop it with frame
// - each grant covers one transaction; rearbitrate before another
// - without grant, master stops when its latency timer expires
// - after target stop, request stays low two clocks around idle
// - master asserts frame on first idle clock with its grant
// - configuration transactions may delay frame for address stepping
package cba_pkg;
   localparam int LAT_W = 8;
   localparam int XFER_W = 4;
   localparam int WAIT_W = 2;
   localparam logic [XFER_W-1:0] XFER_ONE = 4'h1;
   localparam logic [XFER_W-1:0] XFER_TWO = 4'h2;
   localparam logic [WAIT_W-1:0] WAIT_ONE = 2'h1;
   localparam logic [WAIT_W-1:0] WAIT_ZERO = 2'h0;
   // stepping clocks a configuration start waits with grant and idle bus
   localparam logic [WAIT_W-1:0] CFG_STEP_CLKS = 2'h2;
   // clocks of low request after the idle clock that follows a stop
   localparam logic [WAIT_W-1:0] BACK_HOLD_CLKS = 2'h1;
   localparam logic [LAT_W-1:0] LAT_ZERO = 8'h00;
   localparam logic [LAT_W-1:0] LAT_ONE = 8'h01;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_REQ = 6'h02,
      ST_ADDR = 6'h04,
      ST_DATA = 6'h08,
      ST_TURN = 6'h10,
      ST_BACK = 6'h20
   } cba_state_t;
endpackage

/* core/cba_lt_if.sv */
`timescale 1ns/1ps
interface cba_lt_if;
   import cba_pkg::*;
   logic load;
   logic [LAT_W-1:0] value;
   logic expired;
   modport ctl (output load, output value, input expired);
   modport tmr (input load, input value, output expired);
endinterface // cba_lt_if

/* core/cba_lat_timer.sv */
`timescale 1ns/1ps
module cba_lat_timer import cba_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   cba_lt_if.tmr lt
);
   // ==========================================
   // latency countdown, loaded at frame start
   logic [LAT_W-1:0] cnt_reg;
   logic [LAT_W-1:0] cnt_next;

   assign cnt_next = lt.load ? lt.value : ((cnt_reg != LAT_ZERO) ? cnt_reg - LAT_ONE : cnt_reg);
   assign lt.expired = (cnt_reg == LAT_ZERO);

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cnt_reg <= LAT_ZERO;
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
      end
   end
endmodule // cba_lat_timer

/* core/cba_master.sv */
`timescale 1ns/1ps
module cba_master import cba_pkg::*; (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic i_start,
   input wire logic [XFER_W-1:0] i_phases,
   input wire logic i_cfg,
   input wire logic i_more,
   input wire logic [LAT_W-1:0] i_lat_timer,
   output logic o_ready,
   output logic o_done,
   output logic o_stopped,
   output logic o_req_n,
   input wire logic i_gnt_n,
   input wire logic i_frame_n,
   output logic o_frame_n,
   output logic o_frame_oe,
   input wire logic i_irdy_n,
   output logic o_irdy_n,
   output logic o_irdy_oe,
   input wire logic i_trdy_n,
   input wire logic i_stop_n
);
   // ==========================================
   // state and registers
   cba_state_t state_reg;
   cba_state_t state_next;
   logic req_reg;
   logic req_next;
   logic frame_reg;
   logic frame_next;
   logic irdy_reg;
   logic irdy_next;
   logic oe_reg;
   logic oe_next;
   logic [XFER_W-1:0] left_reg;
   logic [XFER_W-1:0] left_next;
   logic [WAIT_W-1:0] wait_reg;
   logic [WAIT_W-1:0] wait_next;
   logic cfg_reg;
   logic cfg_next;
   logic more_reg;
   logic more_next;
   logic stopped_reg;
   logic stopped_next;
   logic done_reg;
   logic done_next;

   cba_lt_if lt ();

   cba_lat_timer u_lat_timer (
      .i_mclk(i_mclk),
      .i_reset_n(i_reset_n),
      .i_ce(i_ce),
      .lt(lt.tmr)
   );

   // ==========================================
   // bus decode
   logic bus_idle;
   logic gnt;
   logic frame_act;
   logic irdy_act;
   logic phase_done;
   logic stop_seen;
   logic can_start;
   logic step_done;
   logic cut_short;

   assign bus_idle = i_frame_n & i_irdy_n;
   assign gnt = ~i_gnt_n;
   assign frame_act = oe_reg & ~frame_reg;
   assign irdy_act = oe_reg & ~irdy_reg;
   assign stop_seen = irdy_act & ~i_stop_n;
   assign phase_done = irdy_act & (~i_trdy_n | ~i_stop_n);
   assign can_start = gnt & bus_idle;
   assign step_done = ~cfg_reg | (wait_reg == CFG_STEP_CLKS);
   assign cut_short = lt.expired & i_gnt_n;
   assign lt.load = (state_reg == ST_REQ) & can_start & step_done;
   assign lt.value = i_lat_timer;

   // ==========================================
   // sequencing
   always_comb begin
      state_next = state_reg;
      req_next = req_reg;
      frame_next = frame_reg;
      irdy_next = irdy_reg;
      oe_next = oe_reg;
      left_next = left_reg;
      wait_next = wait_reg;
      cfg_next = cfg_reg;
      more_next = more_reg;
      stopped_next = stopped_reg;
      done_next = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            req_next = i_start | (req_reg & i_more);
            more_next = i_more;
            if (i_start) begin
               left_next = (i_phases == '0) ? XFER_ONE : i_phases;
               cfg_next = i_cfg;
               wait_next = WAIT_ZERO;
               stopped_next = 1'b0;
               state_next = ST_REQ;
            end
         end
         ST_REQ: begin
            req_next = 1'b1;
            if (can_start && step_done) begin
               // first possible clock unless stepping a config cycle
               frame_next = 1'b0;
               irdy_next = 1'b1;
               oe_next = 1'b1;
               req_next = more_reg;
               state_next = ST_ADDR;
            end else if (can_start) begin
               wait_next = wait_reg + WAIT_ONE;
            end else begin
               wait_next = WAIT_ZERO;
            end
         end
         ST_ADDR: begin
            // transaction stands even if grant is gone now
            irdy_next = 1'b0;
            frame_next = (left_reg == XFER_ONE);
            state_next = ST_DATA;
         end
         ST_DATA: begin
            if (stop_seen) begin
               req_next = 1'b0;
               stopped_next = 1'b1;
            end
            if (phase_done) begin
               left_next = left_reg - XFER_ONE;
            end
            if (phase_done && frame_reg) begin
               irdy_next = 1'b1;
               state_next = ST_TURN;
            end else if (phase_done && (left_reg == XFER_TWO || stop_seen)) begin
               frame_next = 1'b1;
            end else if (cut_short && !frame_reg) begin
               frame_next = 1'b1;
            end
         end
         ST_TURN: begin
            // bus idle clock: drivers high, then released
            oe_next = 1'b0;
            done_next = 1'b1;
            wait_next = WAIT_ZERO;
            if (stopped_reg) begin
               req_next = 1'b0;
               state_next = ST_BACK;
            end else begin
               req_next = req_reg & i_more;
               state_next = ST_IDLE;
            end
         end
         ST_BACK: begin
            req_next = 1'b0;
            wait_next = wait_reg + WAIT_ONE;
            if (wait_reg == BACK_HOLD_CLKS - WAIT_ONE) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
            req_next = 1'b0;
            oe_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_reg <= ST_IDLE;
         req_reg <= 1'b0;
         frame_reg <= 1'b1;
         irdy_reg <= 1'b1;
         oe_reg <= 1'b0;
         left_reg <= XFER_ONE;
         wait_reg <= WAIT_ZERO;
         cfg_reg <= 1'b0;
         more_reg <= 1'b0;
         stopped_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (i_ce) begin
         state_reg <= state_next;
         req_reg <= req_next;
         frame_reg <= frame_next;
         irdy_reg <= irdy_next;
         oe_reg <= oe_next;
         left_reg <= left_next;
         wait_reg <= wait_next;
         cfg_reg <= cfg_next;
         more_reg <= more_next;
         stopped_reg <= stopped_next;
         done_reg <= done_next;
      end
   end

   // ==========================================
   // outputs
   assign o_ready = (state_reg == ST_IDLE);
   assign o_done = done_reg;
   assign o_stopped = done_reg & stopped_reg;
   assign o_req_n = ~req_reg;
   assign o_frame_n = frame_reg;
   assign o_frame_oe = oe_reg;
   assign o_irdy_n = irdy_reg;
   assign o_irdy_oe = oe_reg;

   // ==========================================
   // checks
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   sequence req_low_two_s;
      o_req_n ##1 o_req_n;
   endsequence

   sequence ended_s;
      (o_frame_n && o_irdy_n && o_frame_oe) ##1 (!o_frame_oe && !o_irdy_oe && !frame_act);
   endsequence

   req_need_a: assert property (!o_req_n |-> state_reg != ST_BACK)
      else $error("request asserted during stop backoff");
   start_grant_a: assert property ($rose(frame_act) |-> $past(gnt) && $past(bus_idle))
      else $error("frame started without grant on idle bus");
   prompt_start_a: assert property (i_ce && state_reg == ST_REQ && can_start && !cfg_reg
      |=> frame_act)
      else $error("frame not asserted on first usable clock");
   cfg_step_a: assert property (i_ce && state_reg == ST_REQ && cfg_reg && can_start && wait_reg == WAIT_ZERO
      |=> !frame_act)
      else $error("config start did not wait for stepping");
   grant_loss_a: assert property (i_ce && $rose(frame_act) && i_gnt_n |=> o_irdy_oe && !o_irdy_n)
      else $error("started transaction dropped after grant loss");
   single_drop_a: assert property ($rose(frame_act) && !more_reg |-> o_req_n)
      else $error("request kept for a single transaction");
   idle_end_a: assert property (i_ce && state_reg == ST_TURN |-> ended_s)
      else $error("transaction end not an idle bus state");
   one_per_grant_a: assert property (i_ce && state_reg == ST_TURN |=> !frame_act ##1 !frame_act)
      else $error("second transaction without rearbitration");
   lat_expire_a: assert property (i_ce && state_reg == ST_DATA && cut_short && frame_act
      |=> o_frame_n)
      else $error("frame held past latency timer without grant");
   stop_backoff_a: assert property (i_ce && state_reg == ST_TURN && stopped_reg |-> req_low_two_s)
      else $error("request not held low two clocks after stop");
endmodule // cba_master

/* testbench/cba_arb_model.sv */
`timescale 1ns/1ps
// ==========
// single-agent arbiter, parks on the master
module cba_arb_model (
   input wire logic i_mclk,
   input wire logic i_reset_n,
   input wire logic i_hold,
   input wire logic i_req_n,
   input wire logic i_frame_n,
   input wire logic i_irdy_n,
   output logic o_gnt_n,
   output logic o_broken
);
   // idle clocks with request and grant before the owner counts as broken
   localparam logic [4:0] BROKEN_CLKS = 5'h10;
   logic [4:0] idle_cnt;
   logic bus_idle;
   logic win;
   logic park;
   logic keep;
   logic stall;

   assign bus_idle = i_frame_n & i_irdy_n;
   // sole requester in both rotation levels, so it wins every turn it asks for unless o_broken is set
   assign win = ~i_req_n & ~o_broken;
   // dropped request: nobody else waits, so park on it once idle
   assign park = i_req_n & bus_idle;
   // no requests pending: current grant stays whether or not the bus is idle
   assign keep = i_req_n & ~o_gnt_n;
   assign stall = ~i_req_n & ~o_gnt_n & bus_idle;

   always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_gnt_n <= 1'b1;
         idle_cnt <= 5'h00;
         o_broken <= 1'b0;
      end else begin
         // one grant line only, held off or withdrawn on any edge by i_hold
         o_gnt_n <= i_hold | ~(win | park | keep);
         if (!stall) begin
            idle_cnt <= 5'h00;
         end else if (idle_cnt != BROKEN_CLKS) begin
            idle_cnt <= idle_cnt + 5'h01;
         end
         if (idle_cnt == BROKEN_CLKS) begin
            o_broken <= 1'b1;
         end
      end
   end
endmodule // cba_arb_model

/* testbench/test_central_bus_arbiter.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_central_bus_arbiter;
   import cba_pkg::*;
   typedef struct {logic [3:0] p; logic c; logic m; int lat; int np; logic rq;} cba_row_t;
   logic i_mclk = 1'b0, i_reset_n = 1'b0, i_ce = 1'b1, i_start = 1'b0, i_cfg = 1'b0, i_more = 1'b0;
   logic hold = 1'b0, trdy_n = 1'b0, stop_n = 1'b1, fr_q = 1'b1, broken;
   logic [XFER_W-1:0] i_phases = 4'h1;
   logic [LAT_W-1:0] lat = 8'hff;
   logic o_ready, o_done, o_stopped, o_req_n, gnt_n, o_frame_n, o_frame_oe, o_irdy_n, o_irdy_oe;
   wire logic frame_w = o_frame_oe ? o_frame_n : 1'b1;
   wire logic irdy_w = o_irdy_oe ? o_irdy_n : 1'b1;
   int err_total = 0, n_checks = 0, ph = 0, fr = 0, k = 0;
   cba_row_t rows [6] = '{'{4'h1, 1'b0, 1'b0, 4, 1, 1'b1}, '{4'h0, 1'b0, 1'b0, 4, 1, 1'b1},
      '{4'h3, 1'b0, 1'b1, 6, 3, 1'b0}, '{4'h2, 1'b0, 1'b0, 5, 2, 1'b1}, '{4'h4, 1'b1, 1'b0, 9, 4, 1'b1},
      '{4'hf, 1'b0, 1'b0, 18, 15, 1'b1}};
   always #20 i_mclk = ~i_mclk;
   cba_arb_model arb_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_hold(hold), .i_req_n(o_req_n),
      .i_frame_n(frame_w), .i_irdy_n(irdy_w), .o_gnt_n(gnt_n), .o_broken(broken));
   cba_master dut_u (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_start(i_start),
      .i_phases(i_phases), .i_cfg(i_cfg), .i_more(i_more), .i_lat_timer(lat), .o_ready(o_ready),
      .o_done(o_done), .o_stopped(o_stopped), .o_req_n(o_req_n), .i_gnt_n(gnt_n), .i_frame_n(frame_w),
      .o_frame_n(o_frame_n), .o_frame_oe(o_frame_oe), .i_irdy_n(irdy_w), .o_irdy_n(o_irdy_n),
      .o_irdy_oe(o_irdy_oe), .i_trdy_n(trdy_n), .i_stop_n(stop_n));
   // bus monitor: completed data phases and frame starts
   always @(posedge i_mclk) begin
      if (!irdy_w && !(trdy_n && stop_n)) ph++;
      if (fr_q && !frame_w) fr++;
      fr_q <= frame_w;
   end
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task run(input logic [3:0] p, input logic c, input logic m, output int n);
      @(posedge i_mclk);
      i_phases <= p;
      i_cfg <= c;
      i_more <= m;
      i_start <= 1'b1;
      @(posedge i_mclk);
      i_start <= 1'b0;
      n = 0;
      while (n < 400) begin
         @(posedge i_mclk);
         n++;
         #1;
         if (o_done === 1'b1) break;
      end
      if (n >= 400) `CHK(o_done, 1'b1)
   endtask
   initial begin
      #800000;
      err_total++;
      finish_test();
   end
   initial begin
      @(posedge i_mclk);
      #1;
      `CHK(o_req_n, 1'b1)
      `CHK(o_frame_oe, 1'b0)
      repeat (7) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      #1;
      `CHK(o_done, 1'b0)
      $display("test reset done");
      for (int r = 0; r < 6; r++) begin
         ph = 0;
         fr = 0;
         run(rows[r].p, rows[r].c, rows[r].m, k);
         `CHK(k, rows[r].lat)
         `CHK(ph, rows[r].np)
         `CHK(fr, 1)
         `CHK(o_req_n, rows[r].rq)
         `CHK(o_ready, 1'b1)
         `CHK(o_stopped, 1'b0)
      end
      $display("test rows done");
      // grant withheld: no start until it returns
      ph = 0;
      fr = 0;
      fork
         run(4'h1, 1'b0, 1'b0, k);
         begin
            @(posedge i_mclk);
            hold <= 1'b1;
            repeat (12) @(posedge i_mclk);
            `CHK(fr, 0)
            hold <= 1'b0;
         end
      join
      `CHK(fr, 1)
      $display("test grant hold done");
      // grant removed on the clock frame is driven, short latency timer
      @(posedge i_mclk);
      lat <= 8'h01;
      ph = 0;
      fork
         run(4'h8, 1'b0, 1'b0, k);
         begin
            repeat (2) @(posedge i_mclk);
            hold <= 1'b1;
         end
      join
      `CHK(ph, 2)
      `CHK(ph > 0, 1'b1)
      $display("test latency cut done");
      // target stop ends a burst while more is wanted
      @(posedge i_mclk);
      hold <= 1'b0;
      lat <= 8'hff;
      trdy_n <= 1'b1;
      stop_n <= 1'b0;
      ph = 0;
      run(4'h4, 1'b0, 1'b1, k);
      `CHK(o_stopped, 1'b1)
      `CHK(o_req_n, 1'b1)
      `CHK(o_ready, 1'b0)
      `CHK(ph, 2)
      @(posedge i_mclk);
      trdy_n <= 1'b0;
      stop_n <= 1'b1;
      #1;
      `CHK(o_req_n, 1'b1)
      `CHK(o_done, 1'b0)
      `CHK(o_ready, 1'b1)
      `CHK(broken, 1'b0)
      $display("test stop done");
      finish_test();
   end
endmodule // test_central_bus_arbiter
